// ===== iefb_pkg.sv
// Package: register map, field positions and reset values
package iefb_pkg;
  // Register byte offsets on the APB bus
  localparam logic [7:0] OFS_EDGE_SEL = 8'h00;
  localparam logic [7:0] OFS_CTRL_FIRST = 8'h04;
  localparam logic [7:0] OFS_CTRL_SECOND = 8'h08;
  localparam logic [7:0] OFS_CTRL_THIRD = 8'h0c;
  localparam logic [7:0] OFS_EVT_STATUS = 8'h10;
  localparam logic [7:0] OFS_EVT_CLEAR = 8'h14;
  localparam logic [7:0] OFS_EVT_ENABLE = 8'h18;
  // Reset values
  localparam logic [7:0] RST_EDGE_SEL = 8'h00;
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [1:0] RST_EVT = 2'h0;
  // Edge select coding
  localparam logic [1:0] EDGE_OFF = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
  // Edge select field positions
  localparam int PIN0_SEL_LSB = 0;
  localparam int PIN1_SEL_LSB = 2;
  localparam logic [7:0] EDGE_SEL_MASK = 8'h0f;
  // First control register bits
  localparam int B1_GLOBAL_EN = 0;
  localparam int B1_EXT0_EN = 1;
  localparam int B1_CMP_EN = 2;
  localparam int B1_MF0_EN = 3;
  localparam int B1_EXT0_FLAG = 4;
  localparam int B1_CMP_FLAG = 5;
  localparam int B1_MF0_FLAG = 6;
  localparam logic [7:0] CTRL_FIRST_MASK = 8'h7f;
  // Second control register bits
  localparam int B2_MF1_EN = 0;
  localparam int B2_MF2_EN = 1;
  localparam int B2_CONV_EN = 2;
  localparam int B2_TB0_EN = 3;
  localparam int B2_MF1_FLAG = 4;
  localparam int B2_MF2_FLAG = 5;
  localparam int B2_CONV_FLAG = 6;
  localparam int B2_TB0_FLAG = 7;
  // Third control register bits
  localparam int B3_TB1_EN = 0;
  localparam int B3_EXT1_EN = 1;
  localparam int B3_SER_EN = 2;
  localparam int B3_UART_EN = 3;
  localparam int B3_TB1_FLAG = 4;
  localparam int B3_EXT1_FLAG = 5;
  localparam int B3_SER_FLAG = 6;
  localparam int B3_UART_FLAG = 7;
  // Event status bits: pin edges seen
  localparam int EV_PIN0 = 0;
  localparam int EV_PIN1 = 1;
  // Request vector width
  localparam int NUM_REQ = 10;
endpackage : iefb_pkg

// ===== iefb_edge_if.sv
// Interface: edge detector select and event
`timescale 1ns/10ps
`default_nettype none
interface iefb_edge_if;
  logic [1:0] sel;
  logic evt;
  modport det (input sel, output evt);
  modport ctl (output sel, input evt);
endinterface : iefb_edge_if
`default_nettype wire

// ===== iefb_edge_det.sv
// Pin synchroniser and selectable edge detector
`timescale 1ns/10ps
`default_nettype none
module iefb_edge_det
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_pin,
  iefb_edge_if.det eif
);
  logic [2:0] sync_ff;
  logic lvl_ff;
  logic rise;
  logic fall;

  // Three flops; change taken when second and third agree
  always_ff @(posedge i_clk)
  begin
    sync_ff <= {sync_ff[1:0], i_pin};
  end

  // Level follows the pin in reset; no false edge at release
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      lvl_ff <= sync_ff[2];
    else if (sync_ff[1] == sync_ff[2])
      lvl_ff <= sync_ff[2];
  end

  assign rise = (sync_ff[1] == sync_ff[2]) && sync_ff[2] && !lvl_ff;
  assign fall = (sync_ff[1] == sync_ff[2]) && !sync_ff[2] && lvl_ff;

  always_comb
  begin
    case (eif.sel)
      iefb_pkg::EDGE_OFF: eif.evt = 1'b0;
      iefb_pkg::EDGE_RISE: eif.evt = rise;
      iefb_pkg::EDGE_FALL: eif.evt = fall;
      iefb_pkg::EDGE_BOTH: eif.evt = rise | fall;
      default: eif.evt = 1'b0;
    endcase
  end
endmodule // iefb_edge_det
`default_nettype wire

// ===== iefb_top.sv
// Interrupt enable and flag bank with APB register access
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// - Pin 1 edge field: 00 off, 01 rising, 10 falling, 11 both edges.
// - Pin 0 edge field at bits 1 to 0 uses the same coding.
// - Upper four bits of the edge select register read zero.
// - First control bit 0 is the global enable gating every O_IRQ_REQ request; pin event status reaches O_IRQ ungated.
// - First control bit 4 is the pin 0 flag, set by a selected edge.
// - First control bit 5 is the comparator flag, set by its request.
// - First control bit 2 enables the comparator interrupt.
// - First control bits 6 and 3 are multi-function 0 flag and enable.
// - Second control bits 4, 5 are group 1, 2 flags; bits 0, 1 enables.
// - Second control bits 3, 7 time base 0; bits 6, 2 converter.
// - Third control bit 5 is the pin 1 flag, bit 1 its enable.
// - Third control bit 4 is the time base 1 flag, bit 0 its enable.
// - Third control bits 3, 7 UART; bits 6, 2 serial interface.
module iefb_top
(
  input wire logic I_MCLK,
  input wire logic I_RST_N,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [7:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  input wire logic [3:0] I_PSTRB,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  input wire logic I_EXT_PIN_ZERO,
  input wire logic I_EXT_PIN_ONE,
  input wire logic I_CMP_REQ,
  input wire logic I_MF0_REQ,
  input wire logic I_MF1_REQ,
  input wire logic I_MF2_REQ,
  input wire logic I_CONV_REQ,
  input wire logic I_TB0_REQ,
  input wire logic I_TB1_REQ,
  input wire logic I_SER_REQ,
  input wire logic I_UART_REQ,
  output logic [9:0] O_IRQ_REQ,
  output logic O_IRQ
);
  logic [7:0] edge_sel_ff;
  logic [7:0] ctrl1_ff;
  logic [7:0] ctrl2_ff;
  logic [7:0] ctrl3_ff;
  logic [1:0] evt_stat_ff;
  logic [1:0] evt_en_ff;
  logic [7:0] nxt_ctrl1;
  logic [7:0] nxt_ctrl2;
  logic [7:0] nxt_ctrl3;
  logic [9:0] nxt_req;
  logic [31:0] nxt_rdata;
  logic wr_en;
  logic rd_en;
  logic addr_ok;
  logic wr_lane0;
  logic [7:0] wbyte;
  logic pin0_evt;
  logic pin1_evt;
  logic glb;

  iefb_edge_if eif0();
  iefb_edge_if eif1();

  iefb_edge_det u_det0
  (
    .i_clk(I_MCLK),
    .i_rst_n(I_RST_N),
    .i_pin(I_EXT_PIN_ZERO),
    .eif(eif0)
  );

  iefb_edge_det u_det1
  (
    .i_clk(I_MCLK),
    .i_rst_n(I_RST_N),
    .i_pin(I_EXT_PIN_ONE),
    .eif(eif1)
  );

  assign eif0.sel = edge_sel_ff[iefb_pkg::PIN0_SEL_LSB +: 2];
  assign eif1.sel = edge_sel_ff[iefb_pkg::PIN1_SEL_LSB +: 2];
  assign pin0_evt = eif0.evt;
  assign pin1_evt = eif1.evt;

  // APB decode; single-cycle access phase
  assign wr_en = I_PSEL && I_PENABLE && I_PWRITE;
  assign rd_en = I_PSEL && !I_PWRITE;
  assign wr_lane0 = wr_en && I_PSTRB[0];
  assign wbyte = I_PWDATA[7:0];
  assign O_PREADY = 1'b1;

  always_comb
  begin
    case (I_PADDR)
      iefb_pkg::OFS_EDGE_SEL,
      iefb_pkg::OFS_CTRL_FIRST,
      iefb_pkg::OFS_CTRL_SECOND,
      iefb_pkg::OFS_CTRL_THIRD,
      iefb_pkg::OFS_EVT_STATUS,
      iefb_pkg::OFS_EVT_CLEAR,
      iefb_pkg::OFS_EVT_ENABLE: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end

  assign O_PSLVERR = I_PSEL && I_PENABLE && !addr_ok;

  // Edge select register; upper nibble not stored
  always_ff @(posedge I_MCLK)
  begin
    if (!I_RST_N)
      edge_sel_ff <= iefb_pkg::RST_EDGE_SEL;
    else if (wr_lane0 && I_PADDR == iefb_pkg::OFS_EDGE_SEL)
      edge_sel_ff <= wbyte & iefb_pkg::EDGE_SEL_MASK;
  end

  // First control register: write, then hardware sets win
  always_comb
  begin
    nxt_ctrl1 = ctrl1_ff;
    if (wr_lane0 && I_PADDR == iefb_pkg::OFS_CTRL_FIRST)
      nxt_ctrl1 = wbyte & iefb_pkg::CTRL_FIRST_MASK;
    if (pin0_evt)
      nxt_ctrl1[iefb_pkg::B1_EXT0_FLAG] = 1'b1;
    if (I_CMP_REQ)
      nxt_ctrl1[iefb_pkg::B1_CMP_FLAG] = 1'b1;
    if (I_MF0_REQ)
      nxt_ctrl1[iefb_pkg::B1_MF0_FLAG] = 1'b1;
  end

  always_ff @(posedge I_MCLK)
  begin
    if (!I_RST_N)
      ctrl1_ff <= iefb_pkg::RST_CTRL;
    else
      ctrl1_ff <= nxt_ctrl1;
  end

  // Second control register
  always_comb
  begin
    nxt_ctrl2 = ctrl2_ff;
    if (wr_lane0 && I_PADDR == iefb_pkg::OFS_CTRL_SECOND)
      nxt_ctrl2 = wbyte;
    if (I_MF1_REQ)
      nxt_ctrl2[iefb_pkg::B2_MF1_FLAG] = 1'b1;
    if (I_MF2_REQ)
      nxt_ctrl2[iefb_pkg::B2_MF2_FLAG] = 1'b1;
    if (I_CONV_REQ)
      nxt_ctrl2[iefb_pkg::B2_CONV_FLAG] = 1'b1;
    if (I_TB0_REQ)
      nxt_ctrl2[iefb_pkg::B2_TB0_FLAG] = 1'b1;
  end

  always_ff @(posedge I_MCLK)
  begin
    if (!I_RST_N)
      ctrl2_ff <= iefb_pkg::RST_CTRL;
    else
      ctrl2_ff <= nxt_ctrl2;
  end

  // Third control register
  always_comb
  begin
    nxt_ctrl3 = ctrl3_ff;
    if (wr_lane0 && I_PADDR == iefb_pkg::OFS_CTRL_THIRD)
      nxt_ctrl3 = wbyte;
    if (I_TB1_REQ)
      nxt_ctrl3[iefb_pkg::B3_TB1_FLAG] = 1'b1;
    if (pin1_evt)
      nxt_ctrl3[iefb_pkg::B3_EXT1_FLAG] = 1'b1;
    if (I_SER_REQ)
      nxt_ctrl3[iefb_pkg::B3_SER_FLAG] = 1'b1;
    if (I_UART_REQ)
      nxt_ctrl3[iefb_pkg::B3_UART_FLAG] = 1'b1;
  end

  always_ff @(posedge I_MCLK)
  begin
    if (!I_RST_N)
      ctrl3_ff <= iefb_pkg::RST_CTRL;
    else
      ctrl3_ff <= nxt_ctrl3;
  end

  // Pin edge event status: sticky, clear by write-one, set wins
  always_ff @(posedge I_MCLK)
  begin
    if (!I_RST_N)
      evt_stat_ff <= iefb_pkg::RST_EVT;
    else if (wr_lane0 && I_PADDR == iefb_pkg::OFS_EVT_CLEAR)
      evt_stat_ff <= (evt_stat_ff & ~wbyte[1:0]) | {pin1_evt, pin0_evt};
    else
      evt_stat_ff <= evt_stat_ff | {pin1_evt, pin0_evt};
  end

  always_ff @(posedge I_MCLK)
  begin
    if (!I_RST_N)
      evt_en_ff <= iefb_pkg::RST_EVT;
    else if (wr_lane0 && I_PADDR == iefb_pkg::OFS_EVT_ENABLE)
      evt_en_ff <= wbyte[1:0];
  end

  // Gated requests toward the core
  assign glb = ctrl1_ff[iefb_pkg::B1_GLOBAL_EN];

  always_comb
  begin
    nxt_req[0] = ctrl1_ff[iefb_pkg::B1_EXT0_FLAG] &
                 ctrl1_ff[iefb_pkg::B1_EXT0_EN];
    nxt_req[1] = ctrl1_ff[iefb_pkg::B1_CMP_FLAG] &
                 ctrl1_ff[iefb_pkg::B1_CMP_EN];
    nxt_req[2] = ctrl1_ff[iefb_pkg::B1_MF0_FLAG] &
                 ctrl1_ff[iefb_pkg::B1_MF0_EN];
    nxt_req[3] = ctrl2_ff[iefb_pkg::B2_MF1_FLAG] &
                 ctrl2_ff[iefb_pkg::B2_MF1_EN];
    nxt_req[4] = ctrl2_ff[iefb_pkg::B2_MF2_FLAG] &
                 ctrl2_ff[iefb_pkg::B2_MF2_EN];
    nxt_req[5] = ctrl2_ff[iefb_pkg::B2_CONV_FLAG] &
                 ctrl2_ff[iefb_pkg::B2_CONV_EN];
    nxt_req[6] = ctrl2_ff[iefb_pkg::B2_TB0_FLAG] &
                 ctrl2_ff[iefb_pkg::B2_TB0_EN];
    nxt_req[7] = ctrl3_ff[iefb_pkg::B3_EXT1_FLAG] &
                 ctrl3_ff[iefb_pkg::B3_EXT1_EN];
    nxt_req[8] = ctrl3_ff[iefb_pkg::B3_TB1_FLAG] &
                 ctrl3_ff[iefb_pkg::B3_TB1_EN];
    nxt_req[9] = (ctrl3_ff[iefb_pkg::B3_UART_FLAG] &
                  ctrl3_ff[iefb_pkg::B3_UART_EN]) |
                 (ctrl3_ff[iefb_pkg::B3_SER_FLAG] &
                  ctrl3_ff[iefb_pkg::B3_SER_EN]);
    if (!glb)
      nxt_req = 10'h000;
  end

  assign O_IRQ_REQ = nxt_req;
  assign O_IRQ = (|nxt_req) | (|(evt_stat_ff & evt_en_ff));

  // Read mux, registered into the access phase
  always_comb
  begin
    nxt_rdata = 32'h0000_0000;
    case (I_PADDR)
      iefb_pkg::OFS_EDGE_SEL: nxt_rdata[7:0] = edge_sel_ff;
      iefb_pkg::OFS_CTRL_FIRST: nxt_rdata[7:0] = ctrl1_ff;
      iefb_pkg::OFS_CTRL_SECOND: nxt_rdata[7:0] = ctrl2_ff;
      iefb_pkg::OFS_CTRL_THIRD: nxt_rdata[7:0] = ctrl3_ff;
      iefb_pkg::OFS_EVT_STATUS: nxt_rdata[1:0] = evt_stat_ff;
      iefb_pkg::OFS_EVT_ENABLE: nxt_rdata[1:0] = evt_en_ff;
      default: nxt_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge I_MCLK)
  begin
    if (!I_RST_N)
      O_PRDATA <= 32'h0000_0000;
    else if (rd_en && !I_PENABLE)
      O_PRDATA <= nxt_rdata;
  end
endmodule // iefb_top
`default_nettype wire

// ===== iefb_top_monitor.sv
// Port checker for the interrupt flag bank
`timescale 1ns/10ps
`default_nettype none
module iefb_chk
(
  input wire logic I_MCLK,
  input wire logic I_RST_N,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [7:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  input wire logic [3:0] I_PSTRB,
  input wire logic I_CMP_REQ,
  input wire logic I_MF0_REQ,
  input wire logic I_TB0_REQ,
  input wire logic I_UART_REQ,
  input wire logic [9:0] O_IRQ_REQ,
  input wire logic O_IRQ
);
  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (!I_RST_N);
  logic wr;
  logic [3:0] en1_ff;
  logic [3:0] en2_ff;
  logic [3:0] en3_ff;
  assign wr = I_PSEL & I_PENABLE & I_PWRITE & I_PSTRB[0];
  // Shadow of the enable halves
  always_ff @(posedge I_MCLK)
  begin
    if (!I_RST_N)
    begin
      en1_ff <= 4'h0;
      en2_ff <= 4'h0;
      en3_ff <= 4'h0;
    end
    else if (wr)
    begin
      if (I_PADDR == iefb_pkg::OFS_CTRL_FIRST)
        en1_ff <= I_PWDATA[3:0];
      if (I_PADDR == iefb_pkg::OFS_CTRL_SECOND)
        en2_ff <= I_PWDATA[3:0];
      if (I_PADDR == iefb_pkg::OFS_CTRL_THIRD)
        en3_ff <= I_PWDATA[3:0];
    end
  end
  AST_RST_CLEAR: assert property ($rose(I_RST_N) |-> !O_IRQ)
    else $error("irq after reset");
  AST_GLOBAL_GATE: assert property (!en1_ff[0]
    |-> O_IRQ_REQ == 10'h000)
    else $error("request without global enable");
  AST_CMP_MASK: assert property (!en1_ff[2] |-> !O_IRQ_REQ[1])
    else $error("comparator request while disabled");
  AST_CMP_SET: assert property (I_CMP_REQ && en1_ff[0]
    && en1_ff[2] && !wr |=> O_IRQ_REQ[1])
    else $error("comparator flag not set");
  AST_MF0_SET: assert property (I_MF0_REQ && en1_ff[0]
    && en1_ff[3] && !wr |=> O_IRQ_REQ[2])
    else $error("group 0 flag not set");
  AST_TB0_SET: assert property (I_TB0_REQ && en1_ff[0]
    && en2_ff[3] && !wr |=> O_IRQ_REQ[6])
    else $error("time base 0 flag not set");
  AST_UART_SET: assert property (I_UART_REQ && en1_ff[0]
    && en3_ff[3] && !wr |=> O_IRQ_REQ[9])
    else $error("uart flag not set");
  AST_FLAG_HELD: assert property (O_IRQ_REQ[1] && !wr
    |=> O_IRQ_REQ[1])
    else $error("flag cleared by hardware");
  AST_IRQ_LEVEL: assert property (O_IRQ_REQ != 10'h000 |-> O_IRQ)
    else $error("irq low with request");
  cover property (I_CMP_REQ && en1_ff[2]);
  cover property ($rose(O_IRQ));
  cover property (O_IRQ_REQ[9]);
endmodule // iefb_chk
bind iefb_top iefb_chk iefb_chk_i
(
  .I_MCLK(I_MCLK),
  .I_RST_N(I_RST_N),
  .I_PSEL(I_PSEL),
  .I_PENABLE(I_PENABLE),
  .I_PWRITE(I_PWRITE),
  .I_PADDR(I_PADDR),
  .I_PWDATA(I_PWDATA),
  .I_PSTRB(I_PSTRB),
  .I_CMP_REQ(I_CMP_REQ),
  .I_MF0_REQ(I_MF0_REQ),
  .I_TB0_REQ(I_TB0_REQ),
  .I_UART_REQ(I_UART_REQ),
  .O_IRQ_REQ(O_IRQ_REQ),
  .O_IRQ(O_IRQ)
);
`default_nettype wire

// ===== iefb_src_model.sv
// Model of the pins and peripheral request sources
`timescale 1ns/10ps
`default_nettype none
module iefb_src_model
(
  input wire logic i_clk,
  input wire logic [1:0] i_pin_lvl,
  input wire logic [8:0] i_pulse,
  output logic [1:0] o_pin,
  output logic [8:0] o_req
);
  // Pin levels and requests registered; each request lasts as long as its i_pulse bit
  always_ff @(posedge i_clk)
  begin
    o_pin <= i_pin_lvl;
    o_req <= i_pulse;
  end
endmodule // iefb_src_model
`default_nettype wire

// ===== interrupt_enable_flag_bank_tb.sv
// Testbench of the interrupt flag bank
`timescale 1ns/10ps
`default_nettype none
module interrupt_enable_flag_bank_tb;
  logic clk, rst_n, psel, pen, pwr, pready, pslverr, irq, err;
  logic [7:0] paddr;
  logic [3:0] pstrb;
  logic [31:0] pwdata, prdata, rd;
  logic [9:0] irq_req;
  logic [1:0] pin_lvl, pin;
  logic [8:0] pulse, req;
  int error_cnt, tests_run, cyc;
  iefb_src_model iefb_src_model_i (.i_clk(clk), .i_pin_lvl(pin_lvl),
    .i_pulse(pulse), .o_pin(pin), .o_req(req));
  iefb_top iefb_top_i (.I_MCLK(clk), .I_RST_N(rst_n), .I_PSEL(psel),
    .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata),
    .I_PSTRB(pstrb), .O_PRDATA(prdata), .O_PREADY(pready),
    .O_PSLVERR(pslverr), .I_EXT_PIN_ZERO(pin[0]), .I_EXT_PIN_ONE(pin[1]),
    .I_CMP_REQ(req[0]), .I_MF0_REQ(req[1]), .I_MF1_REQ(req[2]),
    .I_MF2_REQ(req[3]), .I_CONV_REQ(req[4]), .I_TB0_REQ(req[5]),
    .I_TB1_REQ(req[6]), .I_SER_REQ(req[7]), .I_UART_REQ(req[8]),
    .O_IRQ_REQ(irq_req), .O_IRQ(irq));
  task automatic summarize;
    $display("errors=%0d checks=%0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge clk);
    pen <= 1'b1;
    do
    begin
      @(posedge clk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(negedge clk);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 8'h00);
    chk(rd, exp);
  endtask
  task automatic t_reset;
    rdchk(8'h04, 32'h0);
    rdchk(8'h08, 32'h0);
    rdchk(8'h0c, 32'h0);
    apb(1'b1, 8'h00, 8'hff);
    rdchk(8'h00, 32'h0f);
    apb(1'b1, 8'h40, 8'hff);
    chk(err, 1'b1);
    rdchk(8'h40, 32'h0);
    @(posedge clk);
    pstrb <= 4'h0;
    apb(1'b1, 8'h04, 8'h01);
    @(posedge clk);
    pstrb <= 4'h1;
    rdchk(8'h04, 32'h0);
  endtask
  task automatic t_edges;
    int p, m, b;
    logic [7:0] a;
    for (p = 0; p < 2; p++)
      for (m = 0; m < 4; m++)
      begin
        a = p ? 8'h0c : 8'h04;
        b = p ? 5 : 4;
        apb(1'b1, 8'h00, 8'(m << (2 * p)));
        apb(1'b1, a, 8'h00);
        @(posedge clk);
        pin_lvl <= p ? 2'b10 : 2'b01;
        repeat (8) @(posedge clk);
        rdchk(a, 32'(m[0]) << b);
        apb(1'b1, a, 8'h00);
        @(posedge clk);
        pin_lvl <= 2'b00;
        repeat (8) @(posedge clk);
        rdchk(a, 32'(m[1]) << b);
      end
  endtask
  task automatic t_src;
    logic [7:0] ra [9] = '{8'h04, 8'h04, 8'h08, 8'h08, 8'h08, 8'h08,
      8'h0c, 8'h0c, 8'h0c};
    int fb [9] = '{5, 6, 4, 5, 6, 7, 4, 6, 7};
    int ib [9] = '{1, 2, 3, 4, 5, 6, 8, 9, 9};
    for (int i = 0; i < 9; i++)
    begin
      apb(1'b1, 8'h04, 8'h0f);
      apb(1'b1, 8'h08, 8'h0f);
      apb(1'b1, 8'h0c, 8'h0f);
      @(posedge clk);
      pulse <= 9'(1 << i);
      @(posedge clk);
      pulse <= 9'h000;
      repeat (4) @(posedge clk);
      rdchk(ra[i], 32'h0f | (32'h1 << fb[i]));
      chk({22'h0, irq_req}, 32'h1 << ib[i]);
      chk(irq, 1'b1);
      apb(1'b1, 8'h04, ra[i] == 8'h04 ? 8'h0e | 8'(1 << fb[i]) : 8'h0e);
      chk({22'h0, irq_req}, 32'h0);
    end
  endtask
  task automatic t_soft;
    apb(1'b1, 8'h04, 8'h01);
    apb(1'b1, 8'h0c, 8'h00);
    apb(1'b1, 8'h08, 8'h88);
    chk({22'h0, irq_req}, 32'h040);
    apb(1'b1, 8'h08, 8'h00);
    chk({22'h0, irq_req}, 32'h0);
  endtask
  task automatic t_event;
    apb(1'b1, 8'h14, 8'h03);
    apb(1'b1, 8'h00, 8'h01);
    apb(1'b1, 8'h18, 8'h01);
    @(posedge clk);
    pin_lvl[0] <= 1'b1;
    repeat (8) @(posedge clk);
    rdchk(8'h10, 32'h1);
    chk(irq, 1'b1);
    apb(1'b1, 8'h18, 8'h00);
    chk(irq, 1'b0);
    apb(1'b1, 8'h18, 8'h01);
    apb(1'b1, 8'h14, 8'h01);
    rdchk(8'h10, 32'h0);
    chk(irq, 1'b0);
  endtask
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      error_cnt++;
      summarize();
    end
  end
  initial
  begin
    {rst_n, psel, pen, pwr, paddr, pwdata, pin_lvl, pulse} = '0;
    pstrb = 4'h1;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_edges();
    t_src();
    t_soft();
    t_event();
    summarize();
  end
endmodule // interrupt_enable_flag_bank_tb
`default_nettype wire
